// file: rtl/asq_pkg.sv
/*
 Constants, carriers and helpers shared by the converter register block.
 Assumes a seven-bit register address and 24-bit conversion codes.
*/
package asq_pkg;
	// ----------------------------------------
	// Register map and reset values
	// ----------------------------------------
	localparam logic [6:0]  ADDR_GAIN  = 7'h11;
	localparam logic [6:0]  ADDR_OCTL  = 7'h12;
	localparam logic [6:0]  ADDR_QUEUE = 7'h13;
	localparam logic [23:0] GAIN_RST   = 24'hbf851b;
	localparam logic [7:0]  OCTL_RST   = 8'h00;

	// ----------------------------------------
	// Serial frame layout, in bit counts
	// ----------------------------------------
	localparam logic [5:0] CMD_BITS = 6'h08;
	localparam logic [5:0] RD_START = 6'h10;
	localparam logic [5:0] CNT_SAT  = 6'h3f;
	localparam logic [5:0] W_GAIN   = 6'h18;
	localparam logic [5:0] W_OCTL   = 6'h08;
	localparam logic [5:0] W_QUEUE  = 6'h20;

	// ----------------------------------------
	// Queue, datapath and code limits
	// ----------------------------------------
	localparam int          QDEPTH    = 64;
	localparam logic [6:0]  QFULL     = 7'h40;
	localparam int          RAW_W     = 26;
	localparam int          GIN_W     = 25;
	localparam int          PROD_W    = 50;
	localparam int          GAIN_FRAC = 23;
	localparam logic [2:0]  SEQ_M3    = 3'h3;
	localparam logic [2:0]  SEQ_M4    = 3'h4;
	localparam logic [23:0] TC_MAX    = 24'h7fffff;
	localparam logic [23:0] TC_MIN    = 24'h800000;
	localparam logic [23:0] OB_MID    = 24'h800000;
	localparam logic [25:0] RAW_MAX   = 26'h07fffff;
	localparam logic [25:0] RAW_MIN   = 26'h3800000;

	// One stored conversion result.
	typedef struct packed {
		logic        ovw;
		logic [2:0]  rsv;
		logic [2:0]  chan;
		logic        out_of_range_flag;
		logic [23:0] data;
	} asq_entry_s;

	// One result arriving from the conversion datapath.
	typedef struct packed {
		logic [25:0] raw;
		logic [2:0]  chan;
		logic        out_of_range_flag;
	} asq_res_s;

	// One register write handed from the link to the core.
	typedef struct packed {
		logic [6:0]  addr;
		logic [23:0] data;
	} asq_wcmd_s;

	// Data bits carried by a register in a frame.
	function automatic logic [5:0] asq_width(input logic [6:0] a);
		case (a)
			ADDR_GAIN:  asq_width = W_GAIN;
			ADDR_QUEUE: asq_width = W_QUEUE;
			default:    asq_width = W_OCTL;
		endcase
	endfunction : asq_width
endpackage : asq_pkg

// file: rtl/asq_regs.sv
/*
 Register block of the converter: self gain, direct outputs, result queue.
 Assumes the serial link clock stops outside frames and that the
 datapath and control inputs are synchronous to core_clk.
*/
// Summary of operation
// [R1] Gain register is 24 bits, read and written most significant bit first.
// [R2] Readback select 1 returns user gain; 0 returns internal result during conversion.
// [R3] Internal calibration never overwrites the user gain value.
// [R4] Unless bypassed, self-offset-corrected data is scaled by gain before system stages.
// [R5] Gain scales by up to two times, correcting about minus fifty percent.
// [R6] Scaled result is rounded so residual gain error stays within two LSB.
// [R7] Gain writes are blocked while self-calibration runs.
// [R8] In modes 1 and 2 output bits switch outputs on and off at once.
// [R9] In modes 3 and 4 writes to the output register are discarded.
// [R10] In sleep all outputs are off whatever the register holds.
// [R11] In standby with mode 1 or 2, writes update outputs at once.
// [R12] During any calibration outputs follow the output register.
// [R13] Queue keeps 64 newest results; a full queue drops its oldest.
// [R14] Writes to the queue location change nothing.
// [R15] Queue data leaves most significant bit first.
// [R16] Unipolar results are offset binary with midscale 0x800000.
// [R17] Bipolar format bit picks offset binary or two's complement.
// [R18] Out-of-range inputs clamp to the format's end codes.
// [R19] Bit 31 marks an entry that follows an overwrite.
// [R20] Bit 24 carries the channel's out-of-range flag.
// [R21] Entry holds channel in 27:25, result in 23:0, zeros in 30:28.
// [R22] A complete queue read removes the oldest entry; host reads in time.
// [R23] Six output bits map to six outputs; upper two bits do nothing.
`timescale 1ns/1ps
`default_nettype none
module asq_regs
	import asq_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              nrst,
	input  wire logic              ser_clk,
	input  wire logic              ser_sel_n,
	input  wire logic              ser_din,
	output var  logic              ser_dout,
	output var  logic              ser_doe,
	input  wire logic              cal_readback_select,
	input  wire logic              self_gain_bypass,
	input  wire logic              self_cal_busy,
	input  wire logic              cal_active,
	input  wire logic              conv_running,
	input  wire logic [23:0]       cal_gain_int,
	input  wire logic [2:0]        seq_mode,
	input  wire logic              sleep,
	input  wire logic [5:0]        seq_gpo,
	input  wire logic              bipolar,
	input  wire logic              format_offset,
	input  wire logic              res_valid,
	input  wire asq_res_s          res,
	input  wire logic              gin_valid,
	input  wire logic [GIN_W-1:0]  gin,
	output var  logic [5:0]        general_purpose_output,
	output var  logic              gout_valid,
	output var  logic [RAW_W-1:0]  gout,
	output var  logic [6:0]        queue_level
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic              frm_rst_n, rd_frm, wr_tgl, rd_tgl, pop_tgl;
	logic              ack_s1, ack_s2, wr_ev, rd_ev, pop_ev, ack_tgl;
	logic              mode34, ovw_pend, pop, ovr;
	logic [5:0]        bit_cnt, frm_width, wp, rp;
	logic [6:0]        cmd_sh, frm_addr, rd_addr;
	logic [23:0]       wr_sh, self_cal_gain, gain_rb;
	logic [31:0]       tx_sh, rd_hold, rd_val;
	logic [2:0]        wr_s, rd_s, pop_s;
	logic [7:0]        output_direct_control;
	asq_wcmd_s         wcmd;
	asq_entry_s        entry, q_mem [QDEPTH];
	logic [PROD_W-1:0] prod, scaled;

	// ----------------------------------------
	// Link domain: frame decode
	// ----------------------------------------
	// Frame logic is cleared whenever the frame select is released.
	assign frm_rst_n = nrst & ~ser_sel_n;
	assign frm_width = asq_width(frm_addr);

	// Bit counter of the current frame, saturating.
	always_ff @(posedge ser_clk or negedge frm_rst_n) begin
		if (!frm_rst_n) begin
			bit_cnt <= '0;
		end else if (bit_cnt != CNT_SAT) begin
			bit_cnt <= bit_cnt + 6'h01;
		end
	end

	// Command byte capture and write data shifting, MSB first.
	always_ff @(posedge ser_clk or negedge frm_rst_n) begin
		if (!frm_rst_n) begin
			cmd_sh   <= '0;
			rd_frm   <= 1'b0;
			frm_addr <= '0;
			wr_sh    <= '0;
		end else begin
			wr_sh <= {wr_sh[22:0], ser_din}; // [R1]
			if (bit_cnt < CMD_BITS - 6'h01) begin
				cmd_sh <= {cmd_sh[5:0], ser_din};
			end
			if (bit_cnt == CMD_BITS - 6'h01) begin
				rd_frm   <= cmd_sh[6];
				frm_addr <= {cmd_sh[5:0], ser_din};
			end
		end
	end

	// Events for the core; these survive frame end and cross by toggle.
	always_ff @(posedge ser_clk or negedge nrst) begin
		if (!nrst) begin
			wr_tgl  <= 1'b0;
			rd_tgl  <= 1'b0;
			pop_tgl <= 1'b0;
			wcmd    <= '0;
			rd_addr <= '0;
		end else begin
			if (bit_cnt == CMD_BITS - 6'h01 && cmd_sh[6]) begin
				rd_tgl  <= ~rd_tgl;
				rd_addr <= {cmd_sh[5:0], ser_din};
			end
			if (!rd_frm && bit_cnt == CMD_BITS - 6'h01 + frm_width) begin
				wcmd   <= {frm_addr, wr_sh[22:0], ser_din};
				wr_tgl <= ~wr_tgl;
			end
			// The pop is sent only once the last queue bit has been clocked.
			if (rd_frm && frm_addr == ADDR_QUEUE && bit_cnt == RD_START - 6'h01 + W_QUEUE) begin
				pop_tgl <= ~pop_tgl; // [R22]
			end
		end
	end

	// Read acknowledge synchroniser.
	always_ff @(posedge ser_clk or negedge nrst) begin
		if (!nrst) begin
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
		end else begin
			ack_s1 <= ack_tgl;
			ack_s2 <= ack_s1;
		end
	end

	// Read data shifter; an unanswered request sends zeros.
	always_ff @(posedge ser_clk or negedge frm_rst_n) begin
		if (!frm_rst_n) begin
			tx_sh    <= '0;
			ser_dout <= 1'b0;
			ser_doe  <= 1'b0;
		end else if (rd_frm && bit_cnt == RD_START - 6'h01) begin
			tx_sh    <= (ack_s2 == rd_tgl) ? rd_hold : 32'h0;
			ser_dout <= (ack_s2 == rd_tgl) ? rd_hold[31] : 1'b0;
			ser_doe  <= 1'b1;
		end else if (ser_doe) begin
			tx_sh    <= {tx_sh[30:0], 1'b0};
			ser_dout <= tx_sh[30]; // [R15]
			if (bit_cnt == RD_START - 6'h01 + frm_width) begin
				ser_doe  <= 1'b0;
				ser_dout <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Core domain: event crossing
	// ----------------------------------------
	// Toggle synchronisers with edge detection on the settled stages.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wr_s  <= '0;
			rd_s  <= '0;
			pop_s <= '0;
		end else begin
			wr_s  <= {wr_s[1:0], wr_tgl};
			rd_s  <= {rd_s[1:0], rd_tgl};
			pop_s <= {pop_s[1:0], pop_tgl};
		end
	end

	assign wr_ev  = wr_s[2] ^ wr_s[1];
	assign rd_ev  = rd_s[2] ^ rd_s[1];
	assign pop_ev = pop_s[2] ^ pop_s[1];
	assign mode34 = (seq_mode == SEQ_M3) || (seq_mode == SEQ_M4);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// User gain; calibration results live elsewhere and never land here.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			self_cal_gain <= GAIN_RST;
		end else if (wr_ev && wcmd.addr == ADDR_GAIN && !self_cal_busy) begin // [R7]
			self_cal_gain <= wcmd.data; // [R1] [R3]
		end
	end

	// Direct output register; the sequencer owns the outputs in modes 3 and 4.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			output_direct_control <= OCTL_RST;
		end else if (wr_ev && wcmd.addr == ADDR_OCTL && !mode34) begin // [R9]
			output_direct_control <= wcmd.data[7:0];
		end
	end

	// Readback source and left-aligned read word; queue writes go nowhere.
	assign gain_rb = cal_readback_select ? self_cal_gain : (conv_running ? cal_gain_int : 24'h0); // [R2]
	always_comb begin
		case (rd_addr)
			ADDR_GAIN:  rd_val = {gain_rb, 8'h00};
			ADDR_OCTL:  rd_val = {output_direct_control, 24'h0};
			ADDR_QUEUE: rd_val = (queue_level != 7'h00) ? q_mem[rp] : 32'h0; // [R14]
			default:    rd_val = 32'h0;
		endcase
	end

	// Read capture, held stable for the link once acknowledged.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rd_hold <= '0;
			ack_tgl <= 1'b0;
		end else if (rd_ev) begin
			rd_hold <= rd_val;
			ack_tgl <= ~ack_tgl;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Sleep forces outputs off; calibration hands them back to the register.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			general_purpose_output <= 6'h00;
		end else if (sleep) begin
			general_purpose_output <= 6'h00; // [R10]
		end else if (mode34 && !cal_active) begin
			general_purpose_output <= seq_gpo;
		end else begin
			general_purpose_output <= output_direct_control[5:0]; // [R8] [R11] [R12] [R23]
		end
	end

	// ----------------------------------------
	// Self gain correction
	// ----------------------------------------
	// Unsigned gain with 23 fraction bits reaches just under two; rounded.
	assign prod   = PROD_W'($signed(gin) * $signed({1'b0, self_cal_gain})); // [R5]
	assign scaled = PROD_W'($signed(prod + (PROD_W'(1) << (GAIN_FRAC - 1))) >>> GAIN_FRAC); // [R6]

	// Registered corrected sample toward the system correction stages.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			gout       <= '0;
			gout_valid <= 1'b0;
		end else begin
			gout_valid <= gin_valid;
			if (gin_valid) begin
				gout <= self_gain_bypass ? {gin[GIN_W-1], gin} : scaled[RAW_W-1:0]; // [R4]
			end
		end
	end

	// ----------------------------------------
	// Result queue
	// ----------------------------------------
	// Clamp to the end codes, then pick the output coding.
	function automatic logic [23:0] fmt_code(input logic [25:0] raw, input logic tc);
		logic [23:0] c;
		c = raw[23:0];
		if ($signed(raw) > $signed(RAW_MAX)) begin
			c = TC_MAX; // [R18]
		end else if ($signed(raw) < $signed(RAW_MIN)) begin
			c = TC_MIN;
		end
		fmt_code = tc ? c : {~c[23], c[22:0]}; // [R16] [R17]
	endfunction : fmt_code

	assign entry = {ovw_pend, 3'h0, res.chan, res.out_of_range_flag, fmt_code(res.raw, bipolar && !format_offset)}; // [R19] [R20] [R21]
	assign pop   = pop_ev && queue_level != 7'h00;
	assign ovr   = res_valid && queue_level == QFULL && !pop;

	// Storage, one flip-flop word per entry.
	for (genvar i = 0; i < QDEPTH; i++) begin : g_q
		always_ff @(posedge core_clk or negedge nrst) begin
			if (!nrst) begin
				q_mem[i] <= '0;
			end else if (res_valid && wp == 6'(i)) begin
				q_mem[i] <= entry;
			end
		end
	end

	// Pointers and level; a full queue drops its oldest on a new result.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wp          <= '0;
			rp          <= '0;
			queue_level <= '0;
		end else begin
			if (res_valid) begin
				wp <= wp + 6'h01;
			end
			if (pop || ovr) begin
				rp <= rp + 6'h01; // [R13] [R22]
			end
			queue_level <= queue_level + {6'h00, res_valid} - {6'h00, pop || ovr};
		end
	end

	// Overwrite mark carried into the next stored entry.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ovw_pend <= 1'b0;
		end else if (ovr) begin
			ovw_pend <= 1'b1; // [R19]
		end else if (res_valid) begin
			ovw_pend <= 1'b0;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	sequence s_octl_wr;
		wr_ev && wcmd.addr == ADDR_OCTL && !mode34 && !sleep;
	endsequence
	sequence s_octl_hold;
		!sleep && !mode34;
	endsequence

	sleep_off_a: assert property (sleep |=> general_purpose_output == 6'h00) // [R10]
		else $error("outputs not off in sleep");
	gain_lock_a: assert property (wr_ev && wcmd.addr == ADDR_GAIN && self_cal_busy |=> $stable(self_cal_gain)) // [R7]
		else $error("gain written during self calibration");
	octl_drop_a: assert property (wr_ev && wcmd.addr == ADDR_OCTL && mode34 |=> $stable(output_direct_control)) // [R9]
		else $error("output write taken in mode 3 or 4");
	octl_follow_a: assert property (s_octl_wr ##1 s_octl_hold |=> general_purpose_output == $past(wcmd.data[5:0], 2)) // [R8]
		else $error("outputs did not follow the write");
	queue_full_a: assert property (ovr |=> queue_level == QFULL && rp == $past(rp) + 6'h01) // [R13]
		else $error("full queue did not drop oldest");
	ovw_set_a: assert property (ovr |=> ovw_pend) // [R19]
		else $error("overwrite not remembered");
	ovw_mark_a: assert property (res_valid && ovw_pend |=> q_mem[$past(wp)].ovw) // [R19]
		else $error("entry after overwrite not marked");
	clamp_high_a: assert property (res_valid && bipolar && !format_offset && $signed(res.raw) > $signed(RAW_MAX)
		|=> q_mem[$past(wp)].data == TC_MAX) // [R18]
		else $error("high input not clamped");
	uni_mid_a: assert property (res_valid && !bipolar && res.raw == 26'h0 |=> q_mem[$past(wp)].data == OB_MID) // [R16]
		else $error("unipolar midscale code wrong");
	pop_level_a: assert property (pop && !res_valid |=> queue_level == $past(queue_level) - 7'h01) // [R22]
		else $error("queue read did not remove entry");
	bypass_pass_a: assert property (gin_valid && self_gain_bypass |=> gout == {$past(gin[GIN_W-1]), $past(gin)}) // [R4]
		else $error("bypassed sample altered");
	readback_a: assert property (rd_ev && rd_addr == ADDR_GAIN && cal_readback_select
		|=> rd_hold[31:8] == $past(self_cal_gain)) // [R2]
		else $error("user gain readback wrong");
endmodule : asq_regs
`default_nettype wire

// file: tb/asq_host_model.sv
/*
 Host controller model for the serial link of the converter register block.
 Assumes the device samples on rising ser_clk and presents data after it.
*/
`timescale 1ns/1ps
`default_nettype none
module asq_host_model (
	output var  logic ser_clk,
	output var  logic ser_sel_n,
	output var  logic ser_din,
	input  wire logic ser_dout,
	input  wire logic ser_doe
);
	// ----------------------------------------
	// Link timing and frame tasks
	// ----------------------------------------
	localparam int HALF = 16;

	// The link clock stands low between frames.
	initial begin
		ser_clk = 1'b0;
		ser_sel_n = 1'b1;
		ser_din = 1'b0;
	end

	// Free clock edges with the device deselected, used while reset is held.
	task automatic pulse(input int n);
		repeat (n) begin
			#HALF ser_clk = 1'b1;
			#HALF ser_clk = 1'b0;
		end
	endtask : pulse

	// One bit: data set while the clock is low, answer sampled at the falling edge.
	// A bit with the driver off reads as unknown so that it never matches.
	task automatic tick(input logic d, output logic q);
		ser_din = d;
		#HALF ser_clk = 1'b1;
		#HALF q = ser_doe ? ser_dout : 1'bx;
		ser_clk = 1'b0;
	endtask : tick

	// One whole frame: command, then write data or turnaround and read data.
	task automatic xfer(input logic rd, input logic [6:0] a, input logic [31:0] wd, input int n,
			output logic [31:0] q);
		logic b;
		logic [7:0] cmd;
		cmd = {rd, a};
		q = 32'h0;
		b = 1'b0;
		ser_sel_n = 1'b0;
		#HALF;
		for (int i = 7; i >= 0; i--) tick(cmd[i], b);
		if (rd) begin
			for (int i = 0; i < 7; i++) tick(i[0], b);
			for (int i = n - 1; i >= 0; i--) begin
				tick(~ser_din, b);
				q[i] = b;
			end
			tick(~ser_din, b);
		end else begin
			for (int i = n - 1; i >= 0; i--) tick(wd[i], b);
		end
		#HALF ser_sel_n = 1'b1;
		ser_din = ~ser_din;
		#(HALF * 12);
	endtask : xfer
endmodule : asq_host_model
`default_nettype wire

// file: tb/adc_selfgain_output_fifo_regs_tb.sv
/*
 Self-checking bench for the converter register block.
 Assumes asq_host_model drives the serial link; core inputs change on falling core_clk, except cal_active, raised straight after the last output register read.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_selfgain_output_fifo_regs_tb;
	import asq_pkg::*;
	// ----------------------------------------
	// Signals, stimulus tables and design
	// ----------------------------------------
	logic             core_clk, nrst, ser_clk, ser_sel_n, ser_din, ser_dout, ser_doe;
	logic             cal_readback_select, self_gain_bypass, self_cal_busy, cal_active;
	logic             conv_running, sleep, bipolar, format_offset, res_valid, gin_valid, gout_valid;
	logic [23:0]      cal_gain_int;
	logic [2:0]       seq_mode;
	logic [5:0]       seq_gpo, general_purpose_output;
	asq_res_s         res;
	logic [GIN_W-1:0] gin;
	logic [RAW_W-1:0] gout;
	logic [6:0]       queue_level;
	logic [31:0]      d, last;
	logic [31:0]      expq[$];
	logic             pend;
	int               n_mismatch, n_checks, cycles;
	localparam logic [25:0] RAWS [0:7] = '{26'h0, 26'h07fffff, 26'h0800000, 26'h3800000,
		26'h37fffff, 26'h2000000, 26'h0000123, 26'h3ffffff};
	localparam logic [24:0] GINS [0:3] = '{25'h0400000, 25'h1c00000, 25'h0ffffff, 25'h1f00000};
	localparam logic [23:0] GAINS [0:1] = '{24'hffffff, 24'h5a0c31};

	always #12.5 core_clk = ~core_clk;

	asq_host_model u_host (.ser_clk, .ser_sel_n, .ser_din, .ser_dout, .ser_doe);

	asq_regs u_dut (.core_clk, .nrst, .ser_clk, .ser_sel_n, .ser_din, .ser_dout, .ser_doe,
		.cal_readback_select, .self_gain_bypass, .self_cal_busy, .cal_active, .conv_running,
		.cal_gain_int, .seq_mode, .sleep, .seq_gpo, .bipolar, .format_offset, .res_valid, .res,
		.gin_valid, .gin, .general_purpose_output, .gout_valid, .gout, .queue_level);

	// ----------------------------------------
	// Checking, access and reference tasks
	// ----------------------------------------
	// Compares one value and counts it.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [6:0] a, input logic [31:0] v, input int n);
		logic [31:0] q;
		u_host.xfer(1'b0, a, v, n, q);
	endtask : wr

	task automatic rd(input logic [6:0] a, input int n, output logic [31:0] q);
		u_host.xfer(1'b1, a, 32'h0, n, q);
	endtask : rd

	// Expected code: clamp to the 24-bit span, then flip the top bit unless two's complement.
	function automatic logic [23:0] exp_code(input logic [25:0] raw, input logic bip, input logic fo);
		int v;
		v = int'($signed(raw));
		if (v > 8388607) v = 8388607;
		if (v < -8388608) v = -8388608;
		exp_code = v[23:0] ^ {!(bip && !fo), 23'h0};
	endfunction : exp_code

	// Expected scaled sample: unsigned gain with 23 fraction bits, rounded to nearest.
	function automatic logic [25:0] exp_gout(input logic [24:0] g, input logic [23:0] k, input logic byp);
		longint p;
		p = longint'($signed(g));
		if (!byp) p = (p * longint'(k) + 64'sd4194304) >>> 23;
		exp_gout = p[25:0];
	endfunction : exp_gout

	// Pushes one result and mirrors it in the expected queue.
	task automatic push(input int i);
		@(negedge core_clk);
		bipolar = (i % 3) != 0;
		format_offset = i[3];
		res.raw = RAWS[i % 8];
		res.chan = 3'(i % 6);
		res.out_of_range_flag = i[2];
		res_valid = 1'b1;
		d = {pend, 3'h0, res.chan, res.out_of_range_flag, exp_code(res.raw, bipolar, format_offset)};
		pend = expq.size() == QDEPTH;
		if (pend) void'(expq.pop_front());
		expq.push_back(d);
		@(negedge core_clk);
		res_valid = 1'b0;
	endtask : push

	task automatic qpop();
		rd(ADDR_QUEUE, 32, d);
		chk(d, (expq.size() != 0) ? expq.pop_front() : 32'h0);
	endtask : qpop

	task automatic done_test(input string s);
		$display("test %s done, checks %0d", s, n_checks);
	endtask : done_test

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up

	// Cuts a hung run short.
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			wrap_up();
		end
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		{core_clk, nrst, cal_readback_select, self_gain_bypass, self_cal_busy, cal_active} = 6'h0;
		{conv_running, sleep, bipolar, format_offset, res_valid, gin_valid, pend} = 7'h0;
		cal_gain_int = 24'h0;
		seq_mode = 3'h1;
		seq_gpo = 6'h19;
		res = '0;
		gin = '0;
		fork
			u_host.pulse(4);
			repeat (6) @(negedge core_clk);
		join
		nrst = 1'b1;
		cal_readback_select = 1'b1;
		repeat (3) @(negedge core_clk);
		chk(general_purpose_output, 6'h0);
		rd(ADDR_GAIN, 24, d);
		chk(d, GAIN_RST);
		rd(ADDR_OCTL, 8, d);
		chk(d, OCTL_RST);
		wr(ADDR_GAIN, 32'ha5c3e1, 24);
		rd(ADDR_GAIN, 24, d);
		chk(d, 32'ha5c3e1);
		@(negedge core_clk);
		cal_readback_select = 1'b0;
		conv_running = 1'b1;
		cal_gain_int = 24'h13579b;
		rd(ADDR_GAIN, 24, d);
		chk(d, 32'h13579b);
		@(negedge core_clk);
		conv_running = 1'b0;
		rd(ADDR_GAIN, 24, d);
		chk(d, 32'h0);
		@(negedge core_clk);
		cal_readback_select = 1'b1;
		self_cal_busy = 1'b1;
		wr(ADDR_GAIN, 32'h123456, 24);
		@(negedge core_clk);
		self_cal_busy = 1'b0;
		rd(ADDR_GAIN, 24, d);
		chk(d, 32'ha5c3e1);
		rd(7'h20, 8, d);
		chk(d, 32'h0);
		done_test("gain register");

		foreach (GAINS[g]) begin
			wr(ADDR_GAIN, GAINS[g], 24);
			foreach (GINS[j]) begin
				@(negedge core_clk);
				self_gain_bypass = (j == 3);
				gin = GINS[j];
				gin_valid = 1'b1;
				@(negedge core_clk);
				gin_valid = 1'b0;
				for (int k = 0; k < 4 && gout_valid !== 1'b1; k++) @(negedge core_clk);
				chk(gout_valid, 1'b1);
				chk(gout, exp_gout(GINS[j], GAINS[g], j == 3));
			end
		end
		done_test("gain scaling");

		last = 32'h0;
		for (int m = 1; m <= 4; m++) begin
			@(negedge core_clk);
			seq_mode = 3'(m);
			wr(ADDR_OCTL, 32'hc0 + 32'(m * 5), 8);
			if (m < 3) last = 32'hc0 + 32'(m * 5);
			repeat (2) @(negedge core_clk);
			chk(general_purpose_output, (m < 3) ? last[5:0] : seq_gpo);
			rd(ADDR_OCTL, 8, d);
			chk(d, last);
		end
		cal_active = 1'b1;
		repeat (3) @(negedge core_clk);
		chk(general_purpose_output, last[5:0]);
		sleep = 1'b1;
		repeat (3) @(negedge core_clk);
		chk(general_purpose_output, 6'h0);
		{sleep, cal_active} = 2'h0;
		done_test("direct outputs");

		for (int i = 0; i <= QDEPTH; i++) push(i);
		chk(queue_level, QFULL);
		qpop();
		push(QDEPTH + 1);
		@(negedge core_clk);
		chk(queue_level, QFULL);
		wr(ADDR_QUEUE, 32'hffffffff, 32);
		chk(queue_level, QFULL);
		while (expq.size() != 0) qpop();
		qpop();
		chk(queue_level, 7'h0);
		done_test("result queue");
		wrap_up();
	end
endmodule : adc_selfgain_output_fifo_regs_tb
`default_nettype wire
